// *** dcsp_top.sv ***
`timescale 1ns/1ps
`include "dcsp_consts.svh"
module dcsp_top
   import dcsp_pkg::*;
#(
   parameter int COPY_DELAY_CYC = `DCSP_COPY_MIN_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic trim_port_shift_clock,
   input wire logic trim_port_serial_in,
   input wire logic blue_group_ref_clock,
   input wire logic green_group_ref_clock,
   input wire logic red_group_ref_clock,
   input wire logic display_enable,
   output logic trim_port_serial_out,
   output logic [`DCSP_SR_BITS-1:0] holding_latch,
   output logic holding_latch_loaded,
   output logic [`DCSP_GRAY_BITS-1:0] blue_gray_count,
   output logic [`DCSP_GRAY_BITS-1:0] green_gray_count,
   output logic [`DCSP_GRAY_BITS-1:0] red_gray_count,
   output logic display_active,
   output logic trim_port_overrun
);
   function automatic logic rose(input logic prev, input logic cur);
      return cur && !prev;
   endfunction

   function automatic logic [`DCSP_GRAY_BITS-1:0] gray_next(
      input logic [`DCSP_GRAY_BITS-1:0] cnt, input logic en,
      input logic tick);
      logic [`DCSP_GRAY_BITS-1:0] r;
      r = cnt;
      if (!en) begin
         r = '0;
      end else if (tick) begin
         r = cnt + 1'b1;
      end
      return r;
   endfunction

   // Two-stage synchronisers plus one history stage for edge finding
   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic [3:0] hist_reg;
   logic [`DCSP_SR_BITS-1:0] shift_reg;
   logic [`DCSP_TMR_BITS-1:0] idle_tmr_reg;
   dcsp_state_e state_reg;
   dcsp_state_e state_next;

   wire sck_s = sync2_reg[0];
   wire sin_s = sync2_reg[1];
   wire bck_s = sync2_reg[2];
   wire gck_s = sync2_reg[3];
   wire rck_s = sync2_reg[4];
   wire den_s = sync2_reg[5];
   wire sck_rise = rose(hist_reg[0], sck_s);
   wire bck_rise = rose(hist_reg[1], bck_s);
   wire gck_rise = rose(hist_reg[2], gck_s);
   wire rck_rise = rose(hist_reg[3], rck_s);

   dcsp_stream_if bit_q ();

   dcsp_fifo #(
      .WIDTH(`DCSP_FIFO_WIDTH),
      .DEPTH(`DCSP_FIFO_DEPTH),
      .AW(`DCSP_FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .s(bit_q.fifo)
   );

   // Each shift-clock rise pushes the sampled input bit
   assign bit_q.push_valid = sck_rise;
   assign bit_q.push_data = sin_s;
   wire in_copy = (state_reg == DCSP_COPY);
   // Draining stalls while the latch copy runs
   assign bit_q.pop_ready = !in_copy;
   wire bit_take = bit_q.pop_valid && bit_q.pop_ready;
   wire tmr_clear = bit_take || (state_reg != DCSP_WAIT);
   wire tmr_done =
      (idle_tmr_reg == `DCSP_TMR_BITS'(COPY_DELAY_CYC - 1));

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         DCSP_IDLE: begin
            if (bit_take) begin
               state_next = DCSP_WAIT;
            end
         end
         DCSP_WAIT: begin
            if (!bit_take && !bit_q.pop_valid && tmr_done) begin
               state_next = DCSP_COPY;
            end
         end
         DCSP_COPY: begin
            state_next = DCSP_IDLE;
         end
         default: begin
            state_next = DCSP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_reg <= '0;
      end else if (ce) begin
         sync1_reg <= {display_enable, red_group_ref_clock,
            green_group_ref_clock, blue_group_ref_clock,
            trim_port_serial_in, trim_port_shift_clock};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync2_reg <= '0;
      end else if (ce) begin
         sync2_reg <= sync1_reg;
      end
   end

   // Resets to the idle low level, so no false edge follows reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hist_reg <= '0;
      end else if (ce) begin
         hist_reg <= {rck_s, gck_s, bck_s, sck_s};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg <= '0;
      end else if (ce && bit_take) begin
         shift_reg <= {shift_reg[`DCSP_SR_BITS-2:0], bit_q.pop_data[0]};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         trim_port_serial_out <= 1'b0;
      end else if (ce && bit_take) begin
         trim_port_serial_out <= shift_reg[`DCSP_SR_BITS-2];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= DCSP_IDLE;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         idle_tmr_reg <= '0;
      end else if (ce) begin
         if (tmr_clear) begin
            idle_tmr_reg <= '0;
         end else if (!tmr_done) begin
            idle_tmr_reg <= idle_tmr_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         holding_latch_loaded <= 1'b0;
      end else if (ce) begin
         holding_latch_loaded <= in_copy;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         holding_latch <= '0;
      end else if (ce && in_copy) begin
         holding_latch <= shift_reg;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         trim_port_overrun <= 1'b0;
      end else if (ce && sck_rise && !bit_q.push_ready) begin
         trim_port_overrun <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         blue_gray_count <= '0;
      end else if (ce) begin
         blue_gray_count <= gray_next(blue_gray_count, den_s, bck_rise);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         green_gray_count <= '0;
      end else if (ce) begin
         green_gray_count <= gray_next(green_gray_count, den_s, gck_rise);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         red_gray_count <= '0;
      end else if (ce) begin
         red_gray_count <= gray_next(red_gray_count, den_s, rck_rise);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         display_active <= 1'b0;
      end else if (ce) begin
         display_active <= den_s;
      end
   end
endmodule // dcsp_top

// *** dcsp_consts.svh ***
// Operation
// - 216-bit shift register takes the serial input into bit 0 on each rise.
// - Every shift-clock rise moves all bits one place toward the MSB.
// - The register MSB is shown continuously on the serial output.
// - The serial output changes in step with each shift-clock rise.
// - Register copied to holding latch 3 ms to 7 ms after clock stops.
// - Blue counter counts blue reference clock rises while display enabled.
// - Green counter counts green reference clock rises while display enabled.
// - Red counter counts red reference clock rises while display enabled.
`ifndef DCSP_CONSTS_SVH
`define DCSP_CONSTS_SVH
`define DCSP_SR_BITS 216
`define DCSP_GRAY_BITS 12
`define DCSP_CLK_MHZ 100
`define DCSP_COPY_MIN_MS 3
`define DCSP_COPY_MAX_MS 7
`define DCSP_COPY_MIN_CYC (`DCSP_COPY_MIN_MS * 1000 * `DCSP_CLK_MHZ)
`define DCSP_COPY_MAX_CYC (`DCSP_COPY_MAX_MS * 1000 * `DCSP_CLK_MHZ)
`define DCSP_TMR_BITS 20
`define DCSP_FIFO_WIDTH 1
`define DCSP_FIFO_DEPTH 16
`define DCSP_FIFO_AW 4
`endif

// *** dcsp_pkg.sv ***
package dcsp_pkg;
   typedef enum logic [1:0] {
      DCSP_IDLE = 2'h0,
      DCSP_WAIT = 2'h1,
      DCSP_COPY = 2'h3
   } dcsp_state_e;
endpackage

// *** dcsp_stream_if.sv ***
`timescale 1ns/1ps
`include "dcsp_consts.svh"
interface dcsp_stream_if;
   logic push_valid;
   logic push_ready;
   logic [`DCSP_FIFO_WIDTH-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [`DCSP_FIFO_WIDTH-1:0] pop_data;
   modport user (output push_valid, output push_data, input push_ready,
      input pop_valid, input pop_data, output pop_ready);
   modport fifo (input push_valid, input push_data, output push_ready,
      output pop_valid, output pop_data, input pop_ready);
endinterface // dcsp_stream_if

// *** dcsp_fifo.sv ***
`timescale 1ns/1ps
`include "dcsp_consts.svh"
module dcsp_fifo #(
   parameter int WIDTH = `DCSP_FIFO_WIDTH,
   parameter int DEPTH = `DCSP_FIFO_DEPTH,
   parameter int AW = `DCSP_FIFO_AW
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   dcsp_stream_if.fifo s
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] cnt_reg;
   logic out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;
   // The output stage counts as one slot, so DEPTH words in all
   wire mem_full = (cnt_reg == (AW + 1)'(DEPTH - 1));
   wire mem_empty = (cnt_reg == '0);
   wire do_push = s.push_valid && !mem_full;
   wire out_free = !out_valid_reg || s.pop_ready;
   wire do_load = out_free && !mem_empty;
   wire do_drop = out_valid_reg && s.pop_ready && mem_empty;

   assign s.push_ready = !mem_full;
   assign s.pop_valid = out_valid_reg;
   assign s.pop_data = out_data_reg;

   always_ff @(posedge clk) begin
      if (ce && do_push) begin
         mem[wr_ptr_reg] <= s.push_data;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
      end else if (ce) begin
         if (do_push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (do_load) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
            out_data_reg <= mem[rd_ptr_reg];
            out_valid_reg <= 1'b1;
         end else if (do_drop) begin
            out_valid_reg <= 1'b0;
         end
         cnt_reg <= cnt_reg + (AW + 1)'(do_push) - (AW + 1)'(do_load);
      end
   end
endmodule // dcsp_fifo

// *** dcsp_top_asserts.sv ***
`timescale 1ns/1ps
`include "dcsp_consts.svh"
module dcsp_top_asserts #(
   parameter int COPY_DELAY_CYC = 50
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic trim_port_shift_clock,
   input wire logic trim_port_serial_out,
   input wire logic [`DCSP_SR_BITS-1:0] holding_latch,
   input wire logic holding_latch_loaded,
   input wire logic [`DCSP_GRAY_BITS-1:0] blue_gray_count,
   input wire logic [`DCSP_GRAY_BITS-1:0] green_gray_count,
   input wire logic [`DCSP_GRAY_BITS-1:0] red_gray_count,
   input wire logic display_active
);
   logic [19:0] since_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Cycles since the shift-clock pin last rose
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) since_reg <= 20'hfffff;
      else if ($rose(trim_port_shift_clock)) since_reg <= 20'h0;
      else if (since_reg != 20'hfffff) since_reg <= since_reg + 20'h1;
   end
   sequence s_pulse;
      holding_latch_loaded ##1 !holding_latch_loaded;
   endsequence
   a_out_on_shift: assert property (
      $changed(trim_port_serial_out) |-> since_reg <= 20'h8)
      else $error("serial out moved without a shift");
   a_copy_window: assert property (
      holding_latch_loaded |-> since_reg > COPY_DELAY_CYC &&
      since_reg <= COPY_DELAY_CYC + 12) else $error("copy out of window");
   // Latch and its load flag change at the same edge
   a_latch_pulse: assert property (
      $changed(holding_latch) |-> s_pulse) else $error("no load pulse");
   a_off_zero: assert property (
      !display_active && !$past(display_active) |-> blue_gray_count == 0 &&
      green_gray_count == 0 && red_gray_count == 0)
      else $error("count while off");
   a_blue_step: assert property (
      $changed(blue_gray_count) && display_active && $past(display_active)
      |-> blue_gray_count == $past(blue_gray_count) + 12'h1)
      else $error("blue count step");
   a_green_step: assert property (
      $changed(green_gray_count) && display_active && $past(display_active)
      |-> green_gray_count == $past(green_gray_count) + 12'h1)
      else $error("green count step");
   a_red_step: assert property (
      $changed(red_gray_count) && display_active && $past(display_active)
      |-> red_gray_count == $past(red_gray_count) + 12'h1)
      else $error("red count step");
endmodule // dcsp_top_asserts
bind dcsp_top dcsp_top_asserts #(.COPY_DELAY_CYC(COPY_DELAY_CYC)) u_asserts (
   .clk(clk), .sys_rst(sys_rst),
   .trim_port_shift_clock(trim_port_shift_clock),
   .trim_port_serial_out(trim_port_serial_out),
   .holding_latch(holding_latch), .holding_latch_loaded(holding_latch_loaded),
   .blue_gray_count(blue_gray_count),
   .green_gray_count(green_gray_count),
   .red_gray_count(red_gray_count), .display_active(display_active));

// *** dcsp_ctrl_model.sv ***
`timescale 1ns/1ps
`include "dcsp_consts.svh"
module dcsp_ctrl_model (
   input wire logic clk,
   output logic sck,
   output logic sdi
);
   initial begin
      sck = 1'b0;
      sdi = 1'b0;
   end
   // Common latch strobe untouched
   // Most significant bit first, 80 ns clock, still between frames
   task automatic send_bits(input logic [`DCSP_SR_BITS-1:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk);
         sdi <= w[i];
         repeat (3) @(posedge clk);
         sck <= 1'b1;
         repeat (4) @(posedge clk);
         sck <= 1'b0;
      end
      @(posedge clk);
      sdi <= ~sdi;
   endtask
endmodule // dcsp_ctrl_model

// *** dcsp_top_tb_top.sv ***
`timescale 1ns/1ps
`include "dcsp_consts.svh"
module dcsp_top_tb_top;
   localparam int COPY_CYC = 50;
   logic clk, sys_rst, ce_in, sck, sdi, blue, green, red, disp;
   logic sout, loaded, act, ovr;
   logic [`DCSP_SR_BITS-1:0] latch, w1;
   logic [`DCSP_SR_BITS-1:0] exp_q[$];
   logic [`DCSP_GRAY_BITS-1:0] bcnt, gcnt, rcnt;
   logic [31:0] seed;
   int fails, n_checks;
   dcsp_ctrl_model u_ctrl (.clk(clk), .sck(sck), .sdi(sdi));
   dcsp_top #(.COPY_DELAY_CYC(COPY_CYC)) DUT (.clk(clk), .sys_rst(sys_rst),
      .ce(ce_in), .trim_port_shift_clock(sck), .trim_port_serial_in(sdi),
      .blue_group_ref_clock(blue), .green_group_ref_clock(green),
      .red_group_ref_clock(red), .display_enable(disp),
      .trim_port_serial_out(sout), .holding_latch(latch),
      .holding_latch_loaded(loaded), .blue_gray_count(bcnt),
      .green_gray_count(gcnt), .red_gray_count(rcnt), .display_active(act),
      .trim_port_overrun(ovr));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input logic [`DCSP_SR_BITS-1:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wait_drain;
      for (int k = 0; k < 500 && exp_q.size() != 0; k++) @(posedge clk);
      if (exp_q.size() != 0) begin
         fails++;
         report_and_stop();
      end
   endtask
   task automatic pulse_ref(input int nb, ng, nr);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         blue <= i < nb;
         green <= i < ng;
         red <= i < nr;
         repeat (4) @(posedge clk);
         {blue, green, red} <= 3'h0;
         repeat (3) @(posedge clk);
      end
   endtask
   // Each load pulse takes the oldest expected latch image
   always @(posedge clk) begin
      if (loaded === 1'b1)
         chk(latch, exp_q.size() ? exp_q.pop_front() : ~latch);
   end
   initial begin
      {sys_rst, ce_in, disp, blue, green, red} = 6'h30;
      fails = 0;
      n_checks = 0;
      seed = 32'h2898;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         seed = lfsr(seed);
         w1 = {w1[183:0], seed};
      end
      exp_q.push_back(w1);
      u_ctrl.send_bits(w1, 216);
      wait_drain();
      chk(sout, w1[215]);
      $display("test frame done");
      exp_q.push_back({w1[214:0], 1'b1});
      u_ctrl.send_bits(216'h1, 1);
      repeat (12) @(posedge clk);
      chk(sout, w1[214]);
      wait_drain();
      $display("test shift done");
      disp <= 1'b1;
      repeat (6) @(posedge clk);
      pulse_ref(5, 3, 8);
      repeat (6) @(posedge clk);
      chk(bcnt, 5);
      chk(gcnt, 3);
      chk(rcnt, 8);
      chk(act, 1);
      // Pulses while the clock enable is low must not count
      ce_in <= 1'b0;
      pulse_ref(2, 2, 2);
      ce_in <= 1'b1;
      repeat (6) @(posedge clk);
      chk({bcnt, gcnt, rcnt}, {12'h005, 12'h003, 12'h008});
      disp <= 1'b0;
      repeat (6) @(posedge clk);
      pulse_ref(2, 2, 2);
      chk(bcnt | gcnt | rcnt, 0);
      chk({act, ovr}, 0);
      $display("test counters done");
      report_and_stop();
   end
endmodule // dcsp_top_tb_top
